// ==== rtl/tls_pkg.sv ====
// Purpose: Constants, register map and types of the limit register block
// Assumes: Temperature words are twos complement, 128 counts per degree
// Notes:   Shared by the design and by the bench
package tls_pkg;

   // Register addresses carried in command bits 5..3
   localparam logic [2:0]  TLS_ADDR_STAT   = 3'h0;  // 8-bit, not held here
   localparam logic [2:0]  TLS_ADDR_CFG    = 3'h1;  // 8-bit, not held here
   localparam logic [2:0]  TLS_ADDR_TEMP   = 3'h2;  // 16-bit, not held here
   localparam logic [2:0]  TLS_ADDR_ID     = 3'h3;  // 8-bit, not held here
   localparam logic [2:0]  TLS_ADDR_CRIT   = 3'h4;  // Critical limit
   localparam logic [2:0]  TLS_ADDR_HYST   = 3'h5;  // Hysteresis setting
   localparam logic [2:0]  TLS_ADDR_HIGH   = 3'h6;  // High limit
   localparam logic [2:0]  TLS_ADDR_LOW    = 3'h7;  // Low limit

   // Power-on values of the held registers
   localparam logic [15:0] TLS_CRIT_RST    = 16'h4980;  // +147 degrees
   localparam logic [3:0]  TLS_HYST_RST    = 4'h5;      // 5 degrees
   localparam logic [15:0] TLS_HIGH_RST    = 16'h2000;  // +64 degrees
   localparam logic [15:0] TLS_LOW_RST     = 16'h0500;  // +10 degrees

   // Command byte layout
   localparam int          TLS_CMD_DIR     = 6;     // 1 read, 0 write
   localparam int          TLS_CMD_AMSB    = 5;     // Address high bit
   localparam int          TLS_CMD_ALSB    = 3;     // Address low bit

   // Bit counts, as index of the last bit of a phase
   localparam logic [3:0]  TLS_LAST_CMD    = 4'h7;  // 8 command bits
   localparam logic [3:0]  TLS_LAST_8      = 4'h7;  // 8-bit data phase
   localparam logic [3:0]  TLS_LAST_16     = 4'hf;  // 16-bit data phase
   localparam logic [4:0]  TLS_ONES_LAST   = 5'h1f; // 32 ones reset link

   // Hysteresis scaling: one count is one degree
   localparam int          TLS_DEG_SHIFT   = 7;
   localparam logic [5:0]  TLS_HYST_PAD    = 6'h00;
   localparam logic [6:0]  TLS_HYST_LOW    = 7'h00;

   // Limit sources, index into flag and counter arrays
   localparam int          TLS_SRC_HI      = 0;
   localparam int          TLS_SRC_LO      = 1;
   localparam int          TLS_SRC_CR      = 2;
   localparam int          TLS_NSRC        = 3;
   localparam logic [2:0]  TLS_FLT_MAX     = 3'h7;  // Counter saturation

   // Serial parser states
   typedef enum logic [2:0] {
      TLS_ST_CMD = 3'b001,  // Collecting command byte
      TLS_ST_WR  = 3'b010,  // Collecting write data
      TLS_ST_RD  = 3'b100   // Shifting read data out
   } tls_state_e;

endpackage : tls_pkg

// ==== rtl/tls_spi_regs.sv ====
// Purpose: Serial slave with limit setpoints and alarm/critical compare
// Assumes: spi_sclk is its own domain; temperature arrives on clk_sys
// Notes:   Setpoints live at the link and are copied to clk_sys on change
`timescale 1ns/1ps
module tls_spi_regs
   import tls_pkg::*;
(
   // System clock and reset
   input  wire logic        clk_sys,
   input  wire logic        sys_rst,
   // Serial link
   input  wire logic        spi_sclk,
   input  wire logic        spi_cs_n,
   input  wire logic        spi_sdi,
   output logic             spi_sdo,
   output logic             spi_sdo_oe,
   // Temperature from the converter
   input  wire logic [15:0] temp_value,
   input  wire logic        temp_valid,
   // Output behaviour selection
   input  wire logic        cmp_mode,
   input  wire logic [1:0]  fault_queue,
   // Limit outputs
   output logic             alarm_out,
   output logic             critical_out
);
   import tls_pkg::*;

   // Last bit index of the data phase for an address
   function automatic logic [3:0] len_last(input logic [2:0] addr);
      if (addr == TLS_ADDR_HYST || addr == TLS_ADDR_STAT ||
          addr == TLS_ADDR_CFG || addr == TLS_ADDR_ID)
         len_last = TLS_LAST_8;
      else
         len_last = TLS_LAST_16;
   endfunction : len_last

   // Saturating consecutive fault count
   function automatic logic [2:0] cnt_next(input logic       flt,
                                           input logic [2:0] cnt);
      if (!flt)
         cnt_next = 3'h0;
      else if (cnt == TLS_FLT_MAX)
         cnt_next = TLS_FLT_MAX;
      else
         cnt_next = cnt + 3'h1;
   endfunction : cnt_next

   // Link side state
   logic        frm_rst;       // Frame reset: system reset or select high
   tls_state_e  state;         // Parser state
   logic [3:0]  bit_cnt;       // Bit index within phase
   logic [15:0] sh_in;         // Input shift register
   logic [15:0] sh_out;        // Output shift register
   logic [2:0]  cur_addr;      // Address of this frame
   logic [3:0]  cur_last;      // Last bit index of data phase
   logic [4:0]  ones_cnt;      // Consecutive ones seen
   logic        ones_hit;      // 32nd consecutive one
   logic        cmd_done;      // Command byte complete
   logic        wr_fire;       // Write data complete
   logic [7:0]  cmd_byte;      // Command byte including current bit
   logic [15:0] wr_word;       // Write word including current bit
   logic [15:0] crit_reg;      // Critical limit
   logic [3:0]  hyst_reg;      // Hysteresis value
   logic [15:0] high_reg;      // High limit
   logic [15:0] low_reg;       // Low limit
   logic        upd_tgl;       // Toggles when setpoints change
   logic        rd_tgl;        // Toggles on every register read

   assign frm_rst  = sys_rst | spi_cs_n;
   assign cmd_byte = {sh_in[6:0], spi_sdi};
   assign wr_word  = {sh_in[14:0], spi_sdi};
   assign ones_hit = (ones_cnt == TLS_ONES_LAST) && spi_sdi;
   assign cmd_done = (state == TLS_ST_CMD) && (bit_cnt == TLS_LAST_CMD)
                     && !ones_hit;
   assign wr_fire  = (state == TLS_ST_WR) && (bit_cnt == cur_last)
                     && !ones_hit;
   // Driver is enabled only inside a frame
   assign spi_sdo_oe = ~spi_cs_n;

   // Count consecutive ones on the input line
   always_ff @(posedge spi_sclk or posedge frm_rst)
   begin
      if (frm_rst)
         ones_cnt <= 5'h00;
      else if (!spi_sdi)
         ones_cnt <= 5'h00;
      else if (ones_cnt != TLS_ONES_LAST)
         ones_cnt <= ones_cnt + 5'h01;
   end

   // Parser; select high returns it to the command phase
   always_ff @(posedge spi_sclk or posedge frm_rst)
   begin
      if (frm_rst)
      begin
         state    <= TLS_ST_CMD;
         bit_cnt  <= 4'h0;
         cur_addr <= TLS_ADDR_STAT;
         cur_last <= TLS_LAST_8;
      end
      else if (ones_hit)
      begin
         state   <= TLS_ST_CMD;
         bit_cnt <= 4'h0;
      end
      else
      begin
         case (state)
            TLS_ST_CMD:
            begin
               // Command bits sampled on rising edges
               if (bit_cnt == TLS_LAST_CMD)
               begin
                  bit_cnt  <= 4'h0;
                  cur_addr <= cmd_byte[TLS_CMD_AMSB:TLS_CMD_ALSB];
                  cur_last <= len_last(
                     cmd_byte[TLS_CMD_AMSB:TLS_CMD_ALSB]);
                  state    <= cmd_byte[TLS_CMD_DIR] ? TLS_ST_RD
                                                    : TLS_ST_WR;
               end
               else
                  bit_cnt <= bit_cnt + 4'h1;
            end
            TLS_ST_WR, TLS_ST_RD:
            begin
               // One register per command, then await a new command
               if (bit_cnt == cur_last)
               begin
                  state   <= TLS_ST_CMD;
                  bit_cnt <= 4'h0;
               end
               else
                  bit_cnt <= bit_cnt + 4'h1;
            end
            default:
            begin
               state   <= TLS_ST_CMD;
               bit_cnt <= 4'h0;
            end
         endcase
      end
   end

   // Input shifter, most significant bit first
   always_ff @(posedge spi_sclk or posedge frm_rst)
   begin
      if (frm_rst)
         sh_in <= 16'h0000;
      else
         sh_in <= wr_word;
   end

   // Output shifter, loaded at end of command byte
   always_ff @(posedge spi_sclk or posedge frm_rst)
   begin
      if (frm_rst)
         sh_out <= 16'h0000;
      else if (cmd_done)
      begin
         case (cmd_byte[TLS_CMD_AMSB:TLS_CMD_ALSB])
            TLS_ADDR_CRIT: sh_out <= crit_reg;
            TLS_ADDR_HYST: sh_out <= {4'h0, hyst_reg, 8'h00};
            TLS_ADDR_HIGH: sh_out <= high_reg;
            TLS_ADDR_LOW:  sh_out <= low_reg;
            default:       sh_out <= 16'h0000;  // Held elsewhere
         endcase
      end
      else
         sh_out <= {sh_out[14:0], 1'b0};
   end

   // Output pin changes on falling edges only
   always_ff @(negedge spi_sclk or posedge frm_rst)
   begin
      if (frm_rst)
         spi_sdo <= 1'b0;
      else if (state == TLS_ST_RD)
         spi_sdo <= sh_out[15];
      else
         spi_sdo <= 1'b0;
   end

   // Setpoint registers; a partial write never reaches them
   always_ff @(posedge spi_sclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         crit_reg <= TLS_CRIT_RST;
         hyst_reg <= TLS_HYST_RST;
         high_reg <= TLS_HIGH_RST;
         low_reg  <= TLS_LOW_RST;
      end
      else if (ones_hit)
      begin
         crit_reg <= TLS_CRIT_RST;
         hyst_reg <= TLS_HYST_RST;
         high_reg <= TLS_HIGH_RST;
         low_reg  <= TLS_LOW_RST;
      end
      else if (wr_fire)
      begin
         case (cur_addr)
            TLS_ADDR_CRIT: crit_reg <= wr_word;
            TLS_ADDR_HYST: hyst_reg <= wr_word[3:0];
            TLS_ADDR_HIGH: high_reg <= wr_word;
            TLS_ADDR_LOW:  low_reg  <= wr_word;
            default:       crit_reg <= crit_reg;  // Not held here
         endcase
      end
   end

   // Events toward the system domain, as toggles
   always_ff @(posedge spi_sclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         upd_tgl <= 1'b0;
         rd_tgl  <= 1'b0;
      end
      else
      begin
         if (ones_hit || wr_fire)
            upd_tgl <= ~upd_tgl;
         if (cmd_done && cmd_byte[TLS_CMD_DIR])
            rd_tgl <= ~rd_tgl;
      end
   end

   // System side state
   logic [2:0]  upd_sync;      // Update toggle synchroniser and history
   logic [2:0]  rd_sync;       // Read toggle synchroniser and history
   logic        upd_evt;       // Setpoints changed
   logic        rd_evt;        // A register was read
   logic [15:0] crit_s;        // Copies of setpoints
   logic [3:0]  hyst_s;
   logic [15:0] high_s;
   logic [15:0] low_s;
   logic signed [16:0] t_w, hi_w, lo_w, cr_w, hy_w;  // Widened values
   logic [TLS_NSRC-1:0] flt;   // Limit crossed
   logic [TLS_NSRC-1:0] rel;   // Back inside hysteresis band
   logic [TLS_NSRC-1:0] qual;  // Crossing confirmed by fault queue
   logic [TLS_NSRC-1:0] flag;  // Output flags
   logic [TLS_NSRC-1:0] armed; // Ready for a new crossing
   logic [2:0]  flt_cnt [TLS_NSRC];  // Consecutive fault counts

   // Two stages before any use, third for edge detection
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         upd_sync <= 3'h0;
         rd_sync  <= 3'h0;
      end
      else
      begin
         upd_sync <= {upd_sync[1:0], upd_tgl};
         rd_sync  <= {rd_sync[1:0], rd_tgl};
      end
   end
   assign upd_evt = upd_sync[2] ^ upd_sync[1];
   assign rd_evt  = rd_sync[2] ^ rd_sync[1];

   // Copy setpoints; they stand still long after each toggle
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         crit_s <= TLS_CRIT_RST;
         hyst_s <= TLS_HYST_RST;
         high_s <= TLS_HIGH_RST;
         low_s  <= TLS_LOW_RST;
      end
      else if (upd_evt)
      begin
         crit_s <= crit_reg;
         hyst_s <= hyst_reg;
         high_s <= high_reg;
         low_s  <= low_reg;
      end
   end

   // Compare against limits and hysteresis bands
   always_comb
   begin
      t_w  = {temp_value[15], temp_value};
      hi_w = {high_s[15], high_s};
      lo_w = {low_s[15], low_s};
      cr_w = {crit_s[15], crit_s};
      hy_w = {TLS_HYST_PAD, hyst_s, TLS_HYST_LOW};
      flt[TLS_SRC_HI] = t_w > hi_w;
      flt[TLS_SRC_LO] = t_w < lo_w;
      flt[TLS_SRC_CR] = t_w > cr_w;
      rel[TLS_SRC_HI] = t_w < (hi_w - hy_w);
      rel[TLS_SRC_LO] = t_w > (lo_w + hy_w);
      rel[TLS_SRC_CR] = t_w < (cr_w - hy_w);
      for (int i = 0; i < TLS_NSRC; i++)
         qual[i] = temp_valid &&
                   (cnt_next(flt[i], flt_cnt[i]) > {1'b0, fault_queue});
   end

   // Consecutive fault counters, one step per conversion
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         for (int i = 0; i < TLS_NSRC; i++)
            flt_cnt[i] <= 3'h0;
      end
      else if (temp_valid)
      begin
         for (int i = 0; i < TLS_NSRC; i++)
            flt_cnt[i] <= cnt_next(flt[i], flt_cnt[i]);
      end
   end

   // Output flags; a new crossing wins over a read in the same cycle
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         flag  <= 3'h0;
         armed <= 3'h7;
      end
      else
      begin
         for (int i = 0; i < TLS_NSRC; i++)
         begin
            if (cmp_mode)
            begin
               // Comparator: follow crossing and band release
               armed[i] <= 1'b1;
               if (qual[i])
                  flag[i] <= 1'b1;
               else if (temp_valid && rel[i])
                  flag[i] <= 1'b0;
            end
            else
            begin
               // Interrupt: set once, cleared by a read
               if (qual[i] && armed[i])
               begin
                  flag[i]  <= 1'b1;
                  armed[i] <= 1'b0;
               end
               else
               begin
                  if (rd_evt)
                     flag[i] <= 1'b0;
                  if (temp_valid && rel[i])
                     armed[i] <= 1'b1;
               end
            end
         end
      end
   end

   assign alarm_out    = flag[TLS_SRC_HI] | flag[TLS_SRC_LO];
   assign critical_out = flag[TLS_SRC_CR];

   // Checks on the link side
   a_ones_parser: assert property (
      @(posedge spi_sclk) disable iff (frm_rst)
      ones_hit |=> (state == TLS_ST_CMD) && (bit_cnt == 4'h0))
      else $error("Parser not back at command after 32 ones");
   a_ones_regs: assert property (
      @(posedge spi_sclk) disable iff (sys_rst)
      ones_hit |=> (crit_reg == TLS_CRIT_RST) && (hyst_reg == TLS_HYST_RST)
                   && (high_reg == TLS_HIGH_RST) && (low_reg == TLS_LOW_RST))
      else $error("Setpoints not restored after 32 ones");
   a_cmd_dir: assert property (
      @(posedge spi_sclk) disable iff (frm_rst)
      (cmd_done && cmd_byte[TLS_CMD_DIR]) |=> (state == TLS_ST_RD))
      else $error("Read command did not enter read phase");
   a_len_sel: assert property (
      @(posedge spi_sclk) disable iff (frm_rst)
      (cmd_done && (cmd_byte[TLS_CMD_AMSB:TLS_CMD_ALSB] == TLS_ADDR_HYST))
      |=> (cur_last == TLS_LAST_8) ##[1:8] (state == TLS_ST_CMD))
      else $error("Hysteresis phase is not eight bits");
   a_sdo_idle: assert property (
      @(negedge spi_sclk) disable iff (frm_rst)
      (state != TLS_ST_RD) |=> !spi_sdo)
      else $error("Output driven outside read phase");

   // Checks on the system side
   a_cmp_alarm: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      (cmp_mode && qual[TLS_SRC_HI]) |=> alarm_out)
      else $error("Comparator alarm not raised on crossing");
   a_int_read: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      (!cmp_mode && rd_evt && !(qual[TLS_SRC_HI] && armed[TLS_SRC_HI])
       && !(qual[TLS_SRC_LO] && armed[TLS_SRC_LO])) |=> !alarm_out)
      else $error("Read did not clear alarm in interrupt mode");
   a_crit_first: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      (cmp_mode && temp_valid && (fault_queue == 2'h0) &&
       flt[TLS_SRC_CR]) |=> critical_out)
      else $error("Critical output missed a single fault");

endmodule : tls_spi_regs

// ==== testbench/tls_spi_master.sv ====
// Purpose: Behavioural serial master that faces the limit register block
// Assumes: Link clock of 80 ns, idles high, may run free between frames
// Notes:   Frames are issued by the bench through the tasks below
`timescale 1ns/1ps
module tls_spi_master
(
   // Serial link
   output logic spi_sclk,
   output logic spi_cs_n,
   output logic spi_sdi,
   input  wire logic spi_sdo
);
   localparam int HALF = 40;  // Half of the 80 ns link period
   logic tie_low;             // Keep chip select low between frames

   initial
   begin
      spi_sclk = 1'b1;  // Idle high between frames
      spi_cs_n = 1'b1;
      spi_sdi  = 1'b0;
      tie_low  = 1'b0;
   end

   // One frame: command byte, then nd data bits, both MSB first
   task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd,
                       input int nd, output logic [15:0] rd);
      logic [23:0] sh;
      sh = {cmd, wd << (16 - nd)};  // MSB first for any width
      rd = 16'h0000;
      spi_cs_n = 1'b0;  // Frame opens with chip select low
      #HALF;
      for (int i = 0; i < 8 + nd; i++)
      begin
         spi_sclk = 1'b0;  // Drive on falling edge
         spi_sdi  = sh[23 - i];  // Zero in bits 7,2,1,0
         #HALF;
         spi_sclk = 1'b1;  // Sample on rising edge
         if (i >= 8)
         begin
            rd = {rd[14:0], spi_sdo};  // Read data after command
         end
         #HALF;
      end
      if (!tie_low)
      begin
         spi_cs_n = 1'b1;  // One register per frame
      end
      spi_sdi = ~spi_sdi;  // Released line shows no stale value
      #HALF;
   endtask : xfer

   // Run n ones on the data line with chip select low
   task automatic ones(input int n);
      spi_cs_n = 1'b0;
      #HALF;
      for (int i = 0; i < n; i++)
      begin
         spi_sclk = 1'b0;
         spi_sdi  = 1'b1;  // Long run of ones resets the link
         #HALF;
         spi_sclk = 1'b1;
         #HALF;
      end
      if (!tie_low)
      begin
         spi_cs_n = 1'b1;
      end
      spi_sdi = 1'b0;
      #HALF;
   endtask : ones

   // Free running clock with chip select high; it ends low, the way a
   // frame sync master leaves it just before selecting
   task automatic idle(input int n);
      for (int i = 0; i < n; i++)
      begin
         spi_sclk = 1'b1;
         #HALF;
         spi_sclk = 1'b0;  // Clock keeps running between frames
         #HALF;
      end
   endtask : idle

endmodule : tls_spi_master

// ==== testbench/tls_spi_regs_bench.sv ====
// Purpose: Self-checking bench of the limit register block
// Assumes: Master model drives the link; bench drives the temperature
// Notes:   Setpoints are checked through the serial link only
`timescale 1ns/1ps
module tls_spi_regs_bench;
   import tls_pkg::*;

   localparam int LIMIT   = 60000;  // Cycle ceiling of the whole run
   localparam int RST_GAP = 2000;   // Shortened post link reset wait, ns

   logic        clk_sys     = 1'b0;  // System clock
   logic        sys_rst     = 1'b1;  // Active high reset
   logic        spi_sclk;            // Link, from master model
   logic        spi_cs_n;
   logic        spi_sdi;
   logic        spi_sdo;
   logic        spi_sdo_oe;          // Output driver enable
   logic [15:0] temp_value  = 16'h0000;  // Temperature stimulus
   logic        temp_valid  = 1'b0;
   logic        cmp_mode    = 1'b0;      // Interrupt mode default
   logic [1:0]  fault_queue = 2'b00;
   logic        alarm_out;
   logic        critical_out;
   int          miscompares = 0;
   int          tests_run   = 0;
   int          cycles      = 0;

   always #2 clk_sys = ~clk_sys;  // 250 MHz

   tls_spi_regs uut (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .spi_sclk(spi_sclk),
      .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo),
      .spi_sdo_oe(spi_sdo_oe), .temp_value(temp_value),
      .temp_valid(temp_valid),
      .cmp_mode(cmp_mode), .fault_queue(fault_queue),
      .alarm_out(alarm_out), .critical_out(critical_out));

   tls_spi_master u_mst (
      .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi),
      .spi_sdo(spi_sdo));

   // Verdict and end of run
   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up

   // Hang guard
   always @(posedge clk_sys)
   begin
      cycles <= cycles + 1;
      if (cycles == LIMIT)
      begin
         miscompares = miscompares + 1;
         $display("BAD %0t timeout", $time);
         wrap_up();
      end
   end

   // Compare a register value
   task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD %0t reg got %h want %h", $time, got, exp);
      end
   endtask : chk_reg

   // Compare both output pins
   task automatic chk_pin(input logic al, input logic cr);
      tests_run++;
      if (alarm_out !== al || critical_out !== cr)
      begin
         miscompares++;
         $display("BAD %0t pins %b%b want %b%b", $time, alarm_out,
                  critical_out, al, cr);
      end
   endtask : chk_pin

   // Register read over the link
   task automatic rd(input logic [2:0] a, input int n,
                     input logic [15:0] exp);
      logic [15:0] v;
      u_mst.xfer({2'b01, a, 3'b000}, 16'h0000, n, v);
      chk_reg(v, exp);
      chk_reg({15'h0, spi_sdo_oe}, {15'h0, u_mst.tie_low});
   endtask : rd

   // Register write, then let the setpoint reach clk_sys
   task automatic wr(input logic [2:0] a, input int n, input logic [15:0] d);
      logic [15:0] v;
      u_mst.xfer({2'b00, a, 3'b000}, d, n, v);
      repeat (10) @(posedge clk_sys);
   endtask : wr

   // One conversion, checked after the flag flop has settled
   task automatic temp(input logic [15:0] v, input logic al, input logic cr);
      @(posedge clk_sys);
      temp_value <= v;
      temp_valid <= 1'b1;
      @(posedge clk_sys);
      temp_valid <= 1'b0;
      @(posedge clk_sys);
      #1;
      chk_pin(al, cr);
   endtask : temp

   // Power-on values of every held register
   task automatic chk_defaults;
      rd(TLS_ADDR_CRIT, 16, TLS_CRIT_RST);
      rd(TLS_ADDR_HYST, 8, 16'h0005);
      rd(TLS_ADDR_HIGH, 16, TLS_HIGH_RST);
      rd(TLS_ADDR_LOW, 16, TLS_LOW_RST);
   endtask : chk_defaults

   initial
   begin
      repeat (4) @(posedge clk_sys);
      #1;
      chk_pin(1'b0, 1'b0);
      @(posedge clk_sys);
      sys_rst <= 1'b0;
      #3;
      chk_defaults();
      rd(TLS_ADDR_STAT, 8, 16'h0000);
      rd(TLS_ADDR_ID, 8, 16'h0000);
      // Interrupt mode: set, clear by read, no re-set without release
      temp(16'h2100, 1'b1, 1'b0);
      rd(TLS_ADDR_CFG, 8, 16'h0000);
      repeat (5) @(posedge clk_sys);
      temp(16'h2100, 1'b0, 1'b0);
      temp(16'h1d00, 1'b0, 1'b0);
      temp(16'h2100, 1'b1, 1'b0);
      // Comparator mode bands around each limit
      cmp_mode <= 1'b1;
      temp(16'h1e00, 1'b1, 1'b0);
      temp(16'h1d00, 1'b0, 1'b0);
      temp(16'h0400, 1'b1, 1'b0);
      temp(16'h0700, 1'b1, 1'b0);
      temp(16'h0800, 1'b0, 1'b0);
      temp(16'h4a00, 1'b1, 1'b1);
      temp(16'h4800, 1'b1, 1'b1);
      temp(16'h4600, 1'b1, 1'b0);
      // Every fault queue code
      for (int q = 0; q < 4; q++)
      begin
         fault_queue <= q[1:0];
         temp(16'h1d00, 1'b0, 1'b0);
         repeat (q) temp(16'h2100, 1'b0, 1'b0);
         temp(16'h2100, 1'b1, 1'b0);
      end
      fault_queue <= 2'b00;
      // Writes of each held register, unused hysteresis bits dropped
      wr(TLS_ADDR_CRIT, 16, 16'hc180);
      wr(TLS_ADDR_HYST, 8, 16'h00fa);
      wr(TLS_ADDR_HIGH, 16, 16'h2a00);
      wr(TLS_ADDR_LOW, 16, 16'hfb00);
      wr(TLS_ADDR_TEMP, 16, 16'h1234);
      rd(TLS_ADDR_CRIT, 16, 16'hc180);
      rd(TLS_ADDR_HYST, 8, 16'h000a);
      rd(TLS_ADDR_TEMP, 16, 16'h0000);
      temp(16'h2b00, 1'b1, 1'b1);
      temp(16'h2580, 1'b1, 1'b1);
      temp(16'h2480, 1'b0, 1'b1);
      // Free running clock, chip select as frame sync
      u_mst.idle(4);
      rd(TLS_ADDR_CRIT, 16, 16'hc180);
      // Partial write cut short by chip select
      begin
         logic [15:0] v;
         u_mst.xfer(8'h30, 16'h1111, 12, v);
      end
      rd(TLS_ADDR_HIGH, 16, 16'h2a00);
      // Three-wire use, frames back to back
      u_mst.tie_low = 1'b1;
      wr(TLS_ADDR_LOW, 16, 16'h0300);
      rd(TLS_ADDR_LOW, 16, 16'h0300);
      rd(TLS_ADDR_HYST, 8, 16'h000a);
      u_mst.ones(32);
      u_mst.tie_low = 1'b0;
      #RST_GAP;
      chk_defaults();
      temp(16'h2100, 1'b1, 1'b0);
      wrap_up();
   end

endmodule : tls_spi_regs_bench
